// ===== rtl/phy_core_pkg.sv
package phy_core_pkg;

    // Clock rate of the core clock
    localparam int unsigned CLK_HZ            = 200_000_000;
    localparam int unsigned CLK_PERIOD_PS     = 5000;

    // Shortest reset pulse on the reset pin, in ns
    localparam int unsigned RESET_PULSE_NS    = 200;
    localparam int unsigned RESET_PULSE_CYC   =
        (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Release to ready delay, in us (0.54 ms)
    localparam int unsigned READY_DELAY_US    = 540;
    localparam int unsigned READY_DELAY_CYC   = READY_DELAY_US * (CLK_HZ / 1_000_000);

    // Low-speed 32 kHz tick
    localparam int unsigned SLOW_HZ           = 32_000;
    localparam int unsigned SLOW_DIV_CYC      = CLK_HZ / SLOW_HZ;

    // Default UART rate
    localparam int unsigned UART_BAUD         = 9600;
    localparam int unsigned UART_DIV_CYC      = CLK_HZ / UART_BAUD;

    // Reference detect: edges seen within a window
    localparam int unsigned REF_WINDOW_CYC    = 64;
    localparam logic [3:0]  REF_EDGES_MIN     = 4'h4;

    // Reference frequency choices, in kHz
    localparam int unsigned REF_LOW_KHZ       = 19_200;
    localparam int unsigned REF_HIGH_KHZ      = 26_000;

    // Bit stuffing after six ones
    localparam logic [2:0]  STUFF_RUN         = 3'h6;
    localparam logic [2:0]  BIT_LAST          = 3'h7;

    // Pin operating modes
    typedef enum logic [1:0] {
        MODE_ULPI,
        MODE_SERIAL,
        MODE_UART
    } pin_mode_e;

    // Supply presence flags
    typedef struct packed {
        logic battery;
        logic io;
        logic core_1v5;
        logic core_1v8;
        logic analog_3v3;
    } supply_s;

    // Line-side receive samples
    typedef struct packed {
        logic hs_data;
        logic squelch;
        logic ls_fs_diff;
        logic disc_amp;
    } line_rx_s;

endpackage

// ===== rtl/reset_sync.sv
`timescale 1ns/1ps
// Reset that asserts at once and releases on the clock
module reset_sync
(
    // Clock and raw reset request
    input  wire logic i_clk,
    input  wire logic i_hold,
    // Synchronised reset
    output logic      o_reset
);
    logic stage_reg;

    // Assertion at once, release through two flops
    always_ff @(posedge i_clk or posedge i_hold)
    begin
        if (i_hold)
        begin
            stage_reg <= 1'b1;
            o_reset   <= 1'b1;
        end
        else
        begin
            stage_reg <= 1'b0;
            o_reset   <= stage_reg;
        end
    end
endmodule // reset_sync

// ===== rtl/phy_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Clock pin is input out of reset
// - Input mode: ULPI clock feeds PLL
// - Active reference switches clock pin out
// - Output mode accepts one of two references
// - Strap low 19.2 MHz, high 26 MHz
// - Free-running 32 kHz tick generator
// - Chip select or battery loss resets all
// - IO supply loss resets all but slow
// - PHY supplies or reset pin reset PHY
// - Reset pin low 200 ns means reset
// - Direction falls 0.54 ms after release
// - No low-speed when upstream-facing
// - HS transmit: serialise, stuff, NRZI
// - HS receive: squelch, NRZI, unstuff, bytes
// - Detect disconnect during HS transmit
// - LS/FS data goes to recovery stage
// - Serial mode shows raw receiver output
// - LS/FS driver can go high-impedance
// - UART mode maps data pins to line
// - UART default rate is 9600
module phy_core
    import phy_core_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Straps, pins and supplies
    input  wire logic        i_chip_select,
    input  wire logic        i_reset_n_pin,
    input  wire logic        i_reference_clock_in,
    input  wire logic        i_freq_strap,
    input  wire supply_s     i_supply,
    // Mode and role controls
    input  wire pin_mode_e   i_pin_mode,
    input  wire logic        i_upstream_facing,
    input  wire logic        i_low_speed_req,
    input  wire logic        i_hs_tx_en,
    // ULPI transmit bytes
    input  wire logic [7:0]  i_tx_byte,
    input  wire logic        i_tx_valid,
    input  wire logic        i_uart_txd,
    // Line side
    input  wire line_rx_s    i_line,
    // Clock pin and status
    output logic             o_clock_pin_oe,
    output logic             o_ref_26mhz,
    output logic             o_pll_ref_ulpi,
    output logic             o_slow_tick,
    output logic             o_uart_tick,
    output logic             o_phy_reset,
    output logic             o_dir,
    output logic             o_low_speed_en,
    // HS line
    output logic             o_tx_ready,
    output logic             o_hs_line,
    output logic             o_hs_drive,
    output logic             o_disconnect,
    // Receive bytes
    output logic [7:0]       o_rx_byte,
    output logic             o_rx_valid,
    // LS/FS and pass-through
    output logic             o_cdr_in,
    output logic             o_diff_receive_out,
    output logic             o_ls_fs_oe,
    output logic             o_ls_fs_tx,
    output logic             o_uart_rxd
);
    // Reset domains
    logic all_hold, logic_hold, phy_hold;
    logic all_rst, logic_rst, phy_rst;
    logic [$clog2(RESET_PULSE_CYC+1)-1:0] low_cnt_reg;
    logic pin_reset_reg;

    // Whole chip, all but slow, PHY reset requests
    assign all_hold   = i_reset | ~i_chip_select | ~i_supply.battery;
    assign logic_hold = all_hold | ~i_supply.io;
    assign phy_hold   = logic_hold | ~i_supply.core_1v5 | ~i_supply.core_1v8
                      | ~i_supply.analog_3v3 | pin_reset_reg;

    // Reset pin counted low for the minimum pulse
    always_ff @(posedge i_clk)
    begin
        if (all_rst)
        begin
            low_cnt_reg   <= '0;
            pin_reset_reg <= 1'b1;
        end
        else if (!i_reset_n_pin)
        begin
            if (low_cnt_reg != RESET_PULSE_CYC[$bits(low_cnt_reg)-1:0])
                low_cnt_reg <= low_cnt_reg + 1'b1;
            else
                pin_reset_reg <= 1'b1;
        end
        else
        begin
            low_cnt_reg   <= '0;
            pin_reset_reg <= 1'b0;
        end
    end

    // Synchronised releases per domain
    reset_sync u_all   (.i_clk(i_clk), .i_hold(all_hold),   .o_reset(all_rst));
    reset_sync u_logic (.i_clk(i_clk), .i_hold(logic_hold), .o_reset(logic_rst));
    reset_sync u_phy   (.i_clk(i_clk), .i_hold(phy_hold),   .o_reset(phy_rst));

    // Slow 32 kHz tick, only whole-chip reset touches it
    logic [$clog2(SLOW_DIV_CYC)-1:0] slow_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (all_rst)
        begin
            slow_cnt_reg <= '0;
            o_slow_tick  <= 1'b0;
        end
        else
        begin
            o_slow_tick  <= (slow_cnt_reg == '0);
            slow_cnt_reg <= (slow_cnt_reg == SLOW_DIV_CYC[$bits(slow_cnt_reg)-1:0] - 1'b1)
                          ? '0 : slow_cnt_reg + 1'b1;
        end
    end

    // Reference clock detect: count edges in a window
    logic ref_d_reg, ref_seen_reg;
    logic [3:0] edge_cnt_reg;
    logic [$clog2(REF_WINDOW_CYC)-1:0] win_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (logic_rst)
        begin
            ref_d_reg    <= 1'b0;
            edge_cnt_reg <= '0;
            win_cnt_reg  <= '0;
            ref_seen_reg <= 1'b0;
        end
        else
        begin
            ref_d_reg   <= i_reference_clock_in;
            win_cnt_reg <= win_cnt_reg + 1'b1;
            if (win_cnt_reg == '1)
            begin
                ref_seen_reg <= (edge_cnt_reg >= REF_EDGES_MIN);
                edge_cnt_reg <= '0;
            end
            else if (i_reference_clock_in && !ref_d_reg && edge_cnt_reg != '1)
                edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
    end

    // Clock pin direction, PLL source, strap capture after release
    always_ff @(posedge i_clk)
    begin
        if (logic_rst)
        begin
            o_clock_pin_oe <= 1'b0;
            o_pll_ref_ulpi <= 1'b1;
            o_ref_26mhz    <= 1'b0;
        end
        else
        begin
            o_clock_pin_oe <= ref_seen_reg;
            o_pll_ref_ulpi <= ~ref_seen_reg;
            o_ref_26mhz    <= i_freq_strap;
        end
    end

    // Direction held high until lock delay after PHY release
    logic [$clog2(READY_DELAY_CYC+1)-1:0] ready_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (phy_rst)
        begin
            ready_cnt_reg <= '0;
            o_dir         <= 1'b1;
        end
        else if (ready_cnt_reg != READY_DELAY_CYC[$bits(ready_cnt_reg)-1:0])
            ready_cnt_reg <= ready_cnt_reg + 1'b1;
        else
            o_dir <= 1'b0;
    end
    logic phy_ready;
    assign phy_ready = ~o_dir;

    // Reset status and low-speed permission
    always_ff @(posedge i_clk)
    begin
        o_phy_reset <= phy_rst;
        if (phy_rst)
            o_low_speed_en <= 1'b0;
        else
            o_low_speed_en <= i_low_speed_req & ~i_upstream_facing;
    end

    // HS transmitter: shift, stuff, NRZI
    logic [7:0] sh_reg;
    logic [2:0] bit_reg, ones_reg;
    logic       busy_reg, stuff;
    assign stuff = (ones_reg == STUFF_RUN);
    always_ff @(posedge i_clk)
    begin
        if (phy_rst)
        begin
            sh_reg     <= '0;
            bit_reg    <= '0;
            ones_reg   <= '0;
            busy_reg   <= 1'b0;
            o_tx_ready <= 1'b0;
            o_hs_line  <= 1'b1;
            o_hs_drive <= 1'b0;
        end
        else
        begin
            o_tx_ready <= phy_ready & i_hs_tx_en & ~busy_reg & ~o_tx_ready;
            o_hs_drive <= busy_reg;
            if (o_tx_ready && i_tx_valid)
            begin
                sh_reg   <= i_tx_byte;
                bit_reg  <= '0;
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                if (stuff)
                begin
                    o_hs_line <= ~o_hs_line;
                    ones_reg  <= '0;
                end
                else
                begin
                    o_hs_line <= sh_reg[0] ? o_hs_line : ~o_hs_line;
                    ones_reg  <= sh_reg[0] ? ones_reg + 1'b1 : '0;
                    sh_reg    <= {1'b0, sh_reg[7:1]};
                    bit_reg   <= bit_reg + 1'b1;
                    if (bit_reg == BIT_LAST)
                        busy_reg <= 1'b0;
                end
            end
            else if (!i_hs_tx_en)
                ones_reg <= '0;
        end
    end

    // Disconnect seen from doubled amplitude while sending
    always_ff @(posedge i_clk)
    begin
        if (phy_rst)
            o_disconnect <= 1'b0;
        else if (busy_reg && i_line.disc_amp)
            o_disconnect <= 1'b1;
        else if (!i_hs_tx_en)
            o_disconnect <= 1'b0;
    end

    // HS receiver: squelch, NRZI decode, unstuff, bytes
    logic       rx_prev_reg;
    logic [2:0] rx_ones_reg, rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic       rx_bit;
    assign rx_bit = (i_line.hs_data == rx_prev_reg);
    always_ff @(posedge i_clk)
    begin
        if (phy_rst || i_line.squelch)
        begin
            rx_prev_reg <= 1'b1;
            rx_ones_reg <= '0;
            rx_bit_reg  <= '0;
            rx_sh_reg   <= '0;
            o_rx_valid  <= 1'b0;
            o_rx_byte   <= '0;
        end
        else
        begin
            rx_prev_reg <= i_line.hs_data;
            o_rx_valid  <= 1'b0;
            if (rx_ones_reg == STUFF_RUN)
                rx_ones_reg <= '0;
            else
            begin
                rx_ones_reg <= rx_bit ? rx_ones_reg + 1'b1 : '0;
                rx_sh_reg   <= {rx_bit, rx_sh_reg[7:1]};
                rx_bit_reg  <= rx_bit_reg + 1'b1;
                if (rx_bit_reg == BIT_LAST)
                begin
                    o_rx_byte  <= {rx_bit, rx_sh_reg[7:1]};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // UART rate tick
    logic [$clog2(UART_DIV_CYC)-1:0] baud_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (phy_rst)
        begin
            baud_cnt_reg <= '0;
            o_uart_tick  <= 1'b0;
        end
        else
        begin
            o_uart_tick  <= (i_pin_mode == MODE_UART) && (baud_cnt_reg == '0);
            baud_cnt_reg <= (baud_cnt_reg == UART_DIV_CYC[$bits(baud_cnt_reg)-1:0] - 1'b1)
                          ? '0 : baud_cnt_reg + 1'b1;
        end
    end

    // LS/FS paths per pin mode
    always_ff @(posedge i_clk)
    begin
        if (phy_rst)
        begin
            o_cdr_in           <= 1'b0;
            o_diff_receive_out <= 1'b0;
            o_ls_fs_oe         <= 1'b0;
            o_ls_fs_tx         <= 1'b1;
            o_uart_rxd         <= 1'b1;
        end
        else
        begin
            o_cdr_in           <= i_line.ls_fs_diff;
            o_diff_receive_out <= (i_pin_mode == MODE_SERIAL) & i_line.ls_fs_diff;
            case (i_pin_mode)
                MODE_UART:
                begin
                    o_ls_fs_oe <= 1'b1;
                    o_ls_fs_tx <= i_uart_txd;
                    o_uart_rxd <= i_line.ls_fs_diff;
                end
                default:
                begin
                    o_ls_fs_oe <= 1'b0;
                    o_ls_fs_tx <= 1'b1;
                    o_uart_rxd <= 1'b1;
                end
            endcase
        end
    end

    // Assertions
    property p_dir_rel;
        @(posedge i_clk) disable iff (i_reset) $fell(phy_rst) |-> o_dir [*8];
    endproperty
    a_dir_rel: assert property (p_dir_rel) else $error("dir fell too early");
    property p_no_ls_up;
        @(posedge i_clk) disable iff (i_reset) i_upstream_facing |=> !o_low_speed_en;
    endproperty
    a_no_ls_up: assert property (p_no_ls_up) else $error("low speed upstream");
    property p_clk_in_reset;
        @(posedge i_clk) logic_rst |=> !o_clock_pin_oe;
    endproperty
    a_clk_in_reset: assert property (p_clk_in_reset) else $error("clock pin out in reset");
    property p_pll_src;
        @(posedge i_clk) disable iff (logic_rst) o_clock_pin_oe |-> !o_pll_ref_ulpi;
    endproperty
    a_pll_src: assert property (p_pll_src) else $error("pll source wrong");
    // First cycle after PHY release still shows the reset drive state
    property p_uart_map;
        @(posedge i_clk) disable iff (phy_rst)
        (i_pin_mode == MODE_UART && !phy_rst) ##1 (i_pin_mode == MODE_UART) |-> o_ls_fs_oe;
    endproperty
    a_uart_map: assert property (p_uart_map) else $error("uart not driving");
    property p_hiz;
        @(posedge i_clk) disable iff (phy_rst) (i_pin_mode != MODE_UART) |=> !o_ls_fs_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("driver not hiz");
    property p_supply;
        @(posedge i_clk) !i_supply.io |-> ##[1:2] o_phy_reset;
    endproperty
    a_supply: assert property (p_supply) else $error("no reset on supply loss");
    property p_disc;
        @(posedge i_clk) disable iff (phy_rst) busy_reg && i_line.disc_amp |=> o_disconnect;
    endproperty
    a_disc: assert property (p_disc) else $error("disconnect missed");
    c_tx: cover property (@(posedge i_clk) o_tx_ready && i_tx_valid);
    c_rx: cover property (@(posedge i_clk) o_rx_valid);
    c_ref: cover property (@(posedge i_clk) $rose(o_clock_pin_oe));
endmodule // phy_core

// ===== tb/link_model.sv
`timescale 1ns/1ps
// Link side: offers one byte per request and supplies the reference clock
module link_model
(
    // Clock and commands
    input  wire logic       i_clk,
    input  wire logic       i_send,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_ref_on,
    // Handshake from the core
    input  wire logic       i_tx_ready,
    // Towards the core
    output logic [7:0]      o_tx_byte,
    output logic            o_tx_valid,
    output logic            o_ref_clk
);
    logic [1:0] ref_cnt;

    // Idle values at time zero
    initial
    begin
        o_tx_byte  = 8'h00;
        o_tx_valid = 1'b0;
        o_ref_clk  = 1'b0;
        ref_cnt    = 2'h0;
    end

    // Byte held until taken; released data shows its inverse
    always @(posedge i_clk)
    begin
        if (o_tx_valid && i_tx_ready)
        begin
            o_tx_valid <= 1'b0;
            o_tx_byte  <= ~o_tx_byte;
        end
        else if (i_send && !o_tx_valid)
        begin
            o_tx_valid <= 1'b1;
            o_tx_byte  <= i_byte;
        end
    end

    // Reference toggles when enabled, else held at ground
    always @(posedge i_clk)
    begin
        ref_cnt <= (ref_cnt == 2'h2) ? 2'h0 : ref_cnt + 2'h1;
        if (!i_ref_on)
            o_ref_clk <= 1'b0;
        else if (ref_cnt == 2'h2)
            o_ref_clk <= ~o_ref_clk;
    end
endmodule // link_model

// ===== tb/tb_usb_phy_clock_reset_datapath.sv
`timescale 1ns/1ps
module tb_usb_phy_clock_reset_datapath;
    import phy_core_pkg::*;
    // Design inputs
    logic i_clk, i_reset, i_chip_select, i_reset_n_pin, i_reference_clock_in;
    logic i_freq_strap, i_upstream_facing, i_low_speed_req, i_hs_tx_en;
    logic i_tx_valid, i_uart_txd;
    logic [7:0] i_tx_byte;
    supply_s i_supply;
    pin_mode_e i_pin_mode;
    line_rx_s i_line;
    // Design outputs
    logic o_clock_pin_oe, o_ref_26mhz, o_pll_ref_ulpi, o_slow_tick, o_uart_tick;
    logic o_phy_reset, o_dir, o_low_speed_en, o_tx_ready, o_hs_line, o_hs_drive;
    logic o_disconnect, o_rx_valid, o_cdr_in, o_diff_receive_out, o_ls_fs_oe;
    logic o_ls_fs_tx, o_uart_rxd;
    logic [7:0] o_rx_byte;
    // Bench state
    logic send_req, ref_on, ph_q, dir_q;
    logic [7:0] send_byte;
    int n_fail, n_checks, cyc_cnt, rel_at, dir_at;

    phy_core uut (.i_clk, .i_reset, .i_chip_select, .i_reset_n_pin,
        .i_reference_clock_in, .i_freq_strap, .i_supply, .i_pin_mode,
        .i_upstream_facing, .i_low_speed_req, .i_hs_tx_en, .i_tx_byte, .i_tx_valid,
        .i_uart_txd, .i_line, .o_clock_pin_oe, .o_ref_26mhz, .o_pll_ref_ulpi,
        .o_slow_tick, .o_uart_tick, .o_phy_reset, .o_dir, .o_low_speed_en,
        .o_tx_ready, .o_hs_line, .o_hs_drive, .o_disconnect, .o_rx_byte,
        .o_rx_valid, .o_cdr_in, .o_diff_receive_out, .o_ls_fs_oe, .o_ls_fs_tx,
        .o_uart_rxd);

    link_model link (.i_clk(i_clk), .i_send(send_req), .i_byte(send_byte),
        .i_ref_on(ref_on), .i_tx_ready(o_tx_ready), .o_tx_byte(i_tx_byte),
        .o_tx_valid(i_tx_valid), .o_ref_clk(i_reference_clock_in));

    // Clock at 200 MHz
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Cycle stamps of PHY reset release and direction fall
    always @(posedge i_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (ph_q === 1'b1 && o_phy_reset === 1'b0)
            rel_at <= cyc_cnt;
        if (dir_q === 1'b1 && o_dir === 1'b0)
            dir_at <= cyc_cnt;
        ph_q  <= o_phy_reset;
        dir_q <= o_dir;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            n_fail++;
        end
    endtask

    // Cycles between two successive tick pulses
    task automatic gap_of(input bit uart, output int gap);
        int k;
        gap = -1;
        for (k = 0; k < 45000; k++)
        begin
            cyc(1);
            if ((uart ? o_uart_tick : o_slow_tick) === 1'b1)
            begin
                if (gap >= 0)
                    break;
                gap = 0;
            end
            else if (gap >= 0)
                gap++;
        end
        gap++;
    endtask

    task automatic t_clock();
        int s;
        chk(o_clock_pin_oe, 0);
        chk(o_pll_ref_ulpi, 1);
        ref_on = 1'b1;
        cyc(100);
        chk(o_clock_pin_oe, 1);
        chk(o_pll_ref_ulpi, 0);
        for (s = 1; s >= 0; s--)
        begin
            i_freq_strap = s[0];
            cyc(4);
            chk(o_ref_26mhz, s);
        end
    endtask

    task automatic t_modes();
        int g, v;
        gap_of(0, g);
        chk(g, SLOW_DIV_CYC);
        i_pin_mode = MODE_UART;
        gap_of(1, g);
        chk(g, UART_DIV_CYC);
        for (v = 0; v < 4; v++)
        begin
            i_pin_mode = v[1] ? MODE_SERIAL : MODE_UART;
            i_uart_txd = v[0];
            i_line.ls_fs_diff = v[0];
            cyc(4);
            chk(o_cdr_in, v[0]);
            chk(o_ls_fs_oe, !v[1]);
            if (v[1])
                chk(o_diff_receive_out, v[0]);
            else
                chk({o_ls_fs_tx, o_uart_rxd}, {2{v[0]}});
        end
        i_pin_mode = MODE_ULPI;
        i_low_speed_req = 1'b1;
        for (v = 0; v < 2; v++)
        begin
            i_upstream_facing = v[0];
            cyc(4);
            chk(o_low_speed_en, !v[0]);
        end
    endtask

    // Wait for ready; no transmit offer may show while direction is high
    task automatic t_ready();
        int k, early;
        early = 0;
        i_hs_tx_en = 1'b1;
        for (k = 0; k < 110000 && o_dir !== 1'b0; k++)
        begin
            if (o_tx_ready !== 1'b0)
                early++;
            cyc(1);
        end
        cyc(2);
        chk(early, 0);
        chk(dir_at - rel_at, READY_DELAY_CYC);
    endtask

    // Send one byte and decode the NRZI line: 1 means no transition
    task automatic t_tx(input logic [7:0] b, input int n_exp, input logic [15:0] exp);
        logic prev;
        logic [15:0] seen;
        int n, k;
        seen = 16'h0000;
        n = 0;
        send_req = 1'b1;
        send_byte = b;
        cyc(1);
        send_req = 1'b0;
        prev = o_hs_line;
        for (k = 0; k < 40 && n < 16; k++)
        begin
            if (o_hs_drive === 1'b1)
            begin
                seen[n] = (o_hs_line === prev);
                prev = o_hs_line;
                n++;
            end
            else if (n == 0)
                prev = o_hs_line;
            else
                break;
            cyc(1);
        end
        chk(n, n_exp);
        chk(seen, exp);
    endtask

    task automatic t_disc();
        i_line.disc_amp = 1'b1;
        cyc(4);
        chk(o_disconnect, 0);
        i_line.disc_amp = 1'b0;
        i_hs_tx_en = 1'b1;
        t_tx(8'h00, 8, 16'h0000);
        t_tx(8'hFF, 9, 16'h01BF);
        send_req = 1'b1;
        send_byte = 8'h55;
        cyc(1);
        send_req = 1'b0;
        cyc(3);
        i_line.disc_amp = 1'b1;
        cyc(2);
        i_line.disc_amp = 1'b0;
        cyc(12);
        chk(o_disconnect, 1);
        i_hs_tx_en = 1'b0;
        cyc(4);
        chk(o_disconnect, 0);
    endtask

    task automatic t_rx();
        logic [7:0] b;
        int k;
        b = 8'h3C;
        i_line.hs_data = 1'b1;
        i_line.squelch = 1'b0;
        for (k = 0; k < 8; k++)
        begin
            i_line.hs_data = b[k] ? i_line.hs_data : ~i_line.hs_data;
            cyc(1);
        end
        for (k = 0; k < 20 && o_rx_valid !== 1'b1; k++)
            cyc(1);
        chk(o_rx_valid, 1);
        chk(o_rx_byte, b);
        i_line.squelch = 1'b1;
    endtask

    task automatic t_resets();
        int i, g;
        i_reset_n_pin = 1'b0;
        cyc(20);
        i_reset_n_pin = 1'b1;
        cyc(4);
        chk(o_phy_reset, 0);
        i_reset_n_pin = 1'b0;
        cyc(RESET_PULSE_CYC + 4);
        chk({o_phy_reset, o_dir}, 2'h3);
        i_reset_n_pin = 1'b1;
        cyc(4);
        chk(o_phy_reset, 0);
        for (i = 0; i < 6; i++)
        begin
            i_chip_select = (i != 5);
            i_supply = supply_s'(5'h1F ^ (5'h10 >> i));
            cyc(4);
            chk(o_phy_reset, 1);
            if (i < 2 || i == 5)
                chk(o_clock_pin_oe, 0);
            else
                chk(o_clock_pin_oe, 1);
            if (i == 1)
                gap_of(0, g);
            if (i == 1)
                chk(g, SLOW_DIV_CYC);
            i_chip_select = 1'b1;
            i_supply = supply_s'(5'h1F);
            cyc(100);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog over the whole expected run
    initial
    begin
        #(150000 * 5);
        n_fail++;
        conclude();
    end

    // Main sequence
    initial
    begin
        {n_fail, n_checks, cyc_cnt, rel_at, dir_at} = '0;
        {ph_q, dir_q, send_req, ref_on, send_byte} = '0;
        i_reset = 1'b1;
        {i_chip_select, i_reset_n_pin, i_uart_txd} = 3'h7;
        {i_freq_strap, i_upstream_facing, i_low_speed_req, i_hs_tx_en} = 4'h0;
        i_supply = supply_s'(5'h1F);
        i_pin_mode = MODE_ULPI;
        i_line = line_rx_s'(4'h4);
        cyc(12);
        i_reset = 1'b0;
        cyc(4);
        t_clock();
        t_modes();
        t_ready();
        t_disc();
        t_rx();
        t_resets();
        conclude();
    end
endmodule // tb_usb_phy_clock_reset_datapath
